/* File: dv/periph_model.sv */
`timescale 1ns/100ps
// ==========================================================
// Gated peripherals: raise bus accesses and count delivered clock edges
module periph_model
   import clock_gate_pkg::*;
(
   input wire logic [PERIPH_COUNT-1:0] periph_gclk,
   input wire logic access_req,
   input wire logic [3:0] access_unit,
   output periph_enables_t periph_access,
   output int unsigned edge_cnt [PERIPH_COUNT]
);
   // The strobe follows the request, so one bench cycle gives exactly one access.
   assign periph_access = periph_enables_t'(access_req ? 13'h1 << access_unit : 13'h0);
   // A unit counts its own clock edges; a stray or missing pulse shows as a wrong count.
   for (genvar i = 0; i < PERIPH_COUNT; i++) begin : g_cnt
      initial edge_cnt[i] = 0;
      always @(posedge periph_gclk[i]) begin
         edge_cnt[i] <= edge_cnt[i] + 1;
      end
   end
endmodule

/* File: dv/run_mode_peripheral_clock_gating_bench.sv */
`timescale 1ns/100ps
// ==========================================================
// Self-checking bench for the run-mode gating block
module run_mode_peripheral_clock_gating_bench
   import clock_gate_pkg::*;
;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] awaddr = 0, wdata = 0, araddr = 0, sl_w = 0, dp_w = 0;
   logic [3:0] wstrb = 0, access_unit = 0;
   logic sleep_active = 0, deep_active = 0, auto_en = 0, access_req = 0;
   logic awready, wready, bvalid, arready, rvalid, periph_bus_fault, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, run_w;
   logic [12:0] en;
   periph_enables_t periph_access, periph_clk_enable;
   logic [PERIPH_COUNT-1:0] periph_gclk;
   int unsigned edge_cnt [PERIPH_COUNT], snap [PERIPH_COUNT];
   int failures = 0, n_compared = 0;
   logic [33:0] exp_q [$];
   int bits [13] = '{0, 1, 2, 4, 5, 12, 14, 16, 17, 18, 19, 24, 25};

   always #2.5 aclk = ~aclk;

   run_periph_clock_gating i_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
      .rresp(rresp), .sleep_active(sleep_active), .deep_sleep_active(deep_active),
      .auto_sleep_gating_enable(auto_en), .sleep_periph_clock_gate_1(sl_w),
      .deep_sleep_periph_clock_gate_1(dp_w), .periph_access(periph_access),
      .periph_clk_enable(periph_clk_enable), .periph_gclk(periph_gclk),
      .periph_bus_fault(periph_bus_fault), .irq(irq));

   periph_model i_far (.periph_gclk(periph_gclk), .access_req(access_req),
      .access_unit(access_unit), .periph_access(periph_access), .edge_cnt(edge_cnt));

   // ==========================================================
   // Checking and verdict
   task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Bus answers are judged in issue order; sampling at the falling edge avoids races.
   always @(negedge aclk) begin
      if (bvalid && bready) check("bresp", {bresp, 32'h0}, exp_q.pop_front());
      if (rvalid && rready) check("rdata", {rresp, rdata}, exp_q.pop_front());
   end

   // Expected unit enables, worked out from the bit table.
   function automatic logic [12:0] pick(input logic [31:0] w);
      for (int i = 0; i < 13; i++) pick[i] = w[bits[i]];
   endfunction

   // ==========================================================
   // Bus master tasks; each channel is released only after its handshake edge
   task automatic wr(input logic [31:0] a, d, input logic [3:0] s, input logic [1:0] er);
      logic aw_hit, w_hit, b_hit;
      int t;
      exp_q.push_back({er, 32'h0});
      // Start just after an edge, so a back-to-back call never re-raises bready in one step.
      @(posedge aclk);
      awvalid <= 1;
      awaddr <= a;
      wvalid <= 1;
      wdata <= d;
      wstrb <= s;
      bready <= 1;
      t = 0;
      do begin
         @(negedge aclk);
         aw_hit = awvalid && awready;
         w_hit = wvalid && wready;
         b_hit = bvalid;
         @(posedge aclk);
         if (aw_hit) awvalid <= 0;
         if (w_hit) wvalid <= 0;
         if (b_hit) bready <= 0;
         t++;
      end while (!b_hit && t < 100);
      if (!b_hit) failures++;
   endtask

   task automatic rd(input logic [31:0] a, d, input logic [1:0] er);
      logic ar_hit, r_hit;
      int t;
      exp_q.push_back({er, d});
      // Start just after an edge, so a back-to-back call never re-raises rready in one step.
      @(posedge aclk);
      arvalid <= 1;
      araddr <= a;
      rready <= 1;
      t = 0;
      do begin
         @(negedge aclk);
         ar_hit = arvalid && arready;
         r_hit = rvalid;
         @(posedge aclk);
         if (ar_hit) arvalid <= 0;
         if (r_hit) rready <= 0;
         t++;
      end while (!r_hit && t < 100);
      if (!r_hit) failures++;
   endtask

   task automatic settle_en(input logic [12:0] e);
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      check("enables", 34'(periph_clk_enable), 34'(e));
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      logic [31:0] w, sm;
      logic [3:0] s;
      logic [12:0] fu;
      void'($urandom(32'h0e0e));
      fu = 13'h0;
      repeat (4) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      rd(RUN_GATE_ADDR, 32'h0, RESP_OKAY);
      settle_en(13'h0);
      // Each unit alone, so a swapped or dead bit is seen.
      for (int i = 0; i < 13; i++) begin
         wr(RUN_GATE_ADDR, 32'h1 << bits[i], 4'hf, RESP_OKAY);
         rd(RUN_GATE_ADDR, 32'h1 << bits[i], RESP_OKAY);
         settle_en(13'h1 << i);
      end
      wr(RUN_GATE_ADDR, 32'hffff_ffff, 4'hf, RESP_OKAY);
      rd(RUN_GATE_ADDR, 32'h030f_5037, RESP_OKAY);
      run_w = 32'h030f_5037;
      // Random partial writes, merged the way software does a read-modify-write.
      repeat (6) begin
         w = $urandom;
         s = 4'($urandom);
         sm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
         wr(RUN_GATE_ADDR, w, s, RESP_OKAY);
         run_w = ((run_w & ~sm) | (w & sm)) & 32'h030f_5037;
         rd(RUN_GATE_ADDR, run_w, RESP_OKAY);
      end
      wr(SCB_BASE + 32'h108, 32'h1, 4'hf, RESP_SLVERR);
      rd(SCB_BASE + 32'h100, 32'h0, RESP_SLVERR);
      // Gated clocks: enabled units see every edge, stopped units none.
      run_w = 32'h030f_5037 & $urandom & ~32'h1;
      wr(RUN_GATE_ADDR, run_w, 4'hf, RESP_OKAY);
      en = pick(run_w);
      settle_en(en);
      snap = edge_cnt;
      repeat (10) @(posedge aclk);
      @(negedge aclk);
      for (int i = 0; i < 13; i++) begin
         check("gclk", 34'(edge_cnt[i] - snap[i]), en[i] ? 10 : 0);
      end
      // Faults on stopped units raise the interrupt through the status bit.
      wr(IRQ_STATUS_ADDR, 32'h3, 4'hf, RESP_OKAY);
      wr(IRQ_MASK_ADDR, 32'h1, 4'hf, RESP_OKAY);
      for (int i = 0; i < 13; i++) begin
         @(posedge aclk);
         access_unit <= 4'(i);
         access_req <= 1;
         @(posedge aclk);
         access_req <= 0;
         @(negedge aclk);
         check("fault", 34'(periph_bus_fault), 34'(!en[i]));
         if (!en[i]) fu = 13'h1 << i;
      end
      check("irq", 34'(irq), 34'h1);
      // The status shows the fault alone, and the unit register names the last offender.
      rd(IRQ_STATUS_ADDR, 32'h1, RESP_OKAY);
      rd(FAULT_UNIT_ADDR, 32'(fu), RESP_OKAY);
      wr(IRQ_STATUS_ADDR, 32'h3, 4'hf, RESP_OKAY);
      @(negedge aclk);
      check("irq", 34'(irq), 34'h0);
      // Sleep words count only with the auto gating bit set; deep sleep takes priority.
      @(posedge aclk);
      sl_w <= $urandom;
      dp_w <= $urandom;
      sleep_active <= 1;
      settle_en(en);
      @(posedge aclk);
      auto_en <= 1;
      settle_en(pick(sl_w));
      @(posedge aclk);
      deep_active <= 1;
      settle_en(pick(dp_w));
      @(posedge aclk);
      sleep_active <= 0;
      deep_active <= 0;
      auto_en <= 0;
      settle_en(en);
      end_sim();
   end

   // A hang is cut short well past the expected run length.
   initial begin
      #20000;
      failures++;
      end_sim();
   end
endmodule

/* File: rtl/clock_gate_pkg.sv */
// Behaviour
// [R01] A set gating bit clocks its peripheral; a clear bit stops and disables it.
// [R02] Any access to a peripheral whose gating bit is clear answers with a bus fault.
// [R03] After reset the run gating register reads zero; every peripheral starts unclocked.
// [R04] The run gating register supplies the clock enables during normal running.
// [R05] Sleep and deep-sleep gating apply only while the auto sleep gating enable is set.
// [R06] Bit 25 gates comparator b, bit 24 gates comparator a; both read/write.
// [R07] Bits 19 to 16 gate general-purpose counters d, c, b and a.
// [R08] Bit 14 gates two-wire b, bit 12 gates two-wire a; both read/write.
// [R09] Bit 5 gates sync serial b, bit 4 gates sync serial a.
// [R10] Bits 2, 1, 0 gate async serial c, b and a.
// [R11] Unassigned bits are read-only zero; software preserves them on read-modify-write.
// [R12] The run gating register decodes at offset 0x104 of base 0x400F.E000.
// [R13] Enables reach peripherals through glitch-free gating cells, never truncating a pulse.
package clock_gate_pkg;

   // ==========================================================
   // Address map
   localparam logic [31:0] SCB_BASE = 32'h400f_e000;
   localparam logic [31:0] RUN_GATE_OFFSET = 32'h0000_0104;
   localparam logic [31:0] IRQ_STATUS_OFFSET = 32'h0000_01f0;
   localparam logic [31:0] IRQ_MASK_OFFSET = 32'h0000_01f4;
   localparam logic [31:0] FAULT_UNIT_OFFSET = 32'h0000_01f8;
   localparam logic [31:0] RUN_GATE_ADDR = SCB_BASE + RUN_GATE_OFFSET;
   localparam logic [31:0] IRQ_STATUS_ADDR = SCB_BASE + IRQ_STATUS_OFFSET;
   localparam logic [31:0] IRQ_MASK_ADDR = SCB_BASE + IRQ_MASK_OFFSET;
   localparam logic [31:0] FAULT_UNIT_ADDR = SCB_BASE + FAULT_UNIT_OFFSET;

   // ==========================================================
   // Gating register layout
   localparam logic [31:0] RUN_GATE_RESET = 32'h0000_0000;
   localparam logic [31:0] RUN_GATE_RW_MASK = 32'h030f_5037;
   localparam int COMP_B_BIT = 25;
   localparam int COMP_A_BIT = 24;
   localparam int GP_D_BIT = 19;
   localparam int GP_C_BIT = 18;
   localparam int GP_B_BIT = 17;
   localparam int GP_A_BIT = 16;
   localparam int TWI_B_BIT = 14;
   localparam int TWI_A_BIT = 12;
   localparam int SSER_B_BIT = 5;
   localparam int SSER_A_BIT = 4;
   localparam int ASER_C_BIT = 2;
   localparam int ASER_B_BIT = 1;
   localparam int ASER_A_BIT = 0;
   localparam int PERIPH_COUNT = 13;

   // ==========================================================
   // Interrupt status layout
   localparam int STAT_FAULT_BIT = 0;
   localparam int STAT_CHANGE_BIT = 1;
   localparam int STAT_W = 2;
   localparam logic [STAT_W-1:0] STAT_RESET = 2'h0;

   // ==========================================================
   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      MODE_RUN = 2'b00,
      MODE_SLEEP = 2'b01,
      MODE_DEEP = 2'b10
   } power_mode_t;

   // One bit per gated unit, highest register bit first.
   typedef struct packed {
      logic comparator_b_clock_enable;
      logic comparator_a_clock_enable;
      logic gp_counter_d_clock_enable;
      logic gp_counter_c_clock_enable;
      logic gp_counter_b_clock_enable;
      logic gp_counter_a_clock_enable;
      logic two_wire_b_clock_enable;
      logic two_wire_a_clock_enable;
      logic sync_serial_b_clock_enable;
      logic sync_serial_a_clock_enable;
      logic async_serial_c_clock_enable;
      logic async_serial_b_clock_enable;
      logic async_serial_a_clock_enable;
   } periph_enables_t;

   // Gathers the unit bits out of a gating register word.
   function automatic periph_enables_t pick_enables(logic [31:0] r);
      periph_enables_t e;
      e.comparator_b_clock_enable = r[COMP_B_BIT];
      e.comparator_a_clock_enable = r[COMP_A_BIT];
      e.gp_counter_d_clock_enable = r[GP_D_BIT];
      e.gp_counter_c_clock_enable = r[GP_C_BIT];
      e.gp_counter_b_clock_enable = r[GP_B_BIT];
      e.gp_counter_a_clock_enable = r[GP_A_BIT];
      e.two_wire_b_clock_enable = r[TWI_B_BIT];
      e.two_wire_a_clock_enable = r[TWI_A_BIT];
      e.sync_serial_b_clock_enable = r[SSER_B_BIT];
      e.sync_serial_a_clock_enable = r[SSER_A_BIT];
      e.async_serial_c_clock_enable = r[ASER_C_BIT];
      e.async_serial_b_clock_enable = r[ASER_B_BIT];
      e.async_serial_a_clock_enable = r[ASER_A_BIT];
      return e;
   endfunction

   // Expands byte strobes into a bit mask.
   function automatic logic [31:0] strobe_mask(logic [3:0] s);
      return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

endpackage

/* File: rtl/glitch_free_gate.sv */
`timescale 1ns/100ps
// ==========================================================
// Latch-based clock gate cell
module glitch_free_gate (
   input wire logic clk_in,
   input wire logic enable,
   output logic clk_out
);

   logic en_latched;

   // The enable is only taken while the clock is low, so a change can never cut a high phase.
   always_latch begin
      if (!clk_in) begin
         en_latched <= enable; // [R13]
      end
   end

   assign clk_out = clk_in & en_latched; // [R13]

endmodule

/* File: rtl/run_periph_clock_gating.sv */
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/100ps
// ==========================================================
// Run-mode peripheral clock gating with AXI4-Lite register access
module run_periph_clock_gating
   import clock_gate_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [31:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic sleep_active,
   input wire logic deep_sleep_active,
   input wire logic auto_sleep_gating_enable,
   input wire logic [31:0] sleep_periph_clock_gate_1,
   input wire logic [31:0] deep_sleep_periph_clock_gate_1,
   input wire periph_enables_t periph_access,
   output periph_enables_t periph_clk_enable,
   output logic [PERIPH_COUNT-1:0] periph_gclk,
   output logic periph_bus_fault,
   output logic irq
);

   // ==========================================================
   // State
   logic [31:0] run_periph_clock_gate_1_ff;
   logic [STAT_W-1:0] irq_status_ff;
   logic [STAT_W-1:0] irq_mask_ff;
   periph_enables_t fault_unit_ff;
   periph_enables_t enable_ff;
   periph_enables_t nxt_enable;
   periph_enables_t fault_vec;
   logic bus_fault_ff;
   logic aw_held_ff;
   logic [31:0] wr_addr_ff;
   logic w_held_ff;
   logic [31:0] wr_data_ff;
   logic [3:0] wr_strb_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic do_write;
   logic wr_run;
   logic wr_hit;
   logic [31:0] wr_bits;
   logic [31:0] rd_word;
   logic rd_hit;
   logic [STAT_W-1:0] stat_set;
   logic [STAT_W-1:0] stat_clr;
   logic [31:0] sel_gate;
   power_mode_t mode;

   // ==========================================================
   // Write channels
   // Address and data are each parked until both are in; either may arrive first.
   assign awready = !aw_held_ff && !bvalid_ff;
   assign wready = !w_held_ff && !bvalid_ff;
   assign do_write = aw_held_ff && w_held_ff;
   assign wr_bits = strobe_mask(wr_strb_ff);
   assign wr_run = do_write && (wr_addr_ff == RUN_GATE_ADDR); // [R12]
   assign wr_hit = (wr_addr_ff == RUN_GATE_ADDR) || (wr_addr_ff == IRQ_STATUS_ADDR) ||
                   (wr_addr_ff == IRQ_MASK_ADDR) || (wr_addr_ff == FAULT_UNIT_ADDR);

   // Write address holding.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_ff <= 1'b0;
         wr_addr_ff <= 32'h0000_0000;
      end else if (awvalid && awready) begin
         aw_held_ff <= 1'b1;
         wr_addr_ff <= awaddr;
      end else if (do_write) begin
         aw_held_ff <= 1'b0;
      end
   end

   // Write data holding.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_ff <= 1'b0;
         wr_data_ff <= 32'h0000_0000;
         wr_strb_ff <= 4'h0;
      end else if (wvalid && wready) begin
         w_held_ff <= 1'b1;
         wr_data_ff <= wdata;
         wr_strb_ff <= wstrb;
      end else if (do_write) begin
         w_held_ff <= 1'b0;
      end
   end

   // Write response; an unmapped address is refused with a slave error.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
      end else if (do_write) begin
         bvalid_ff <= 1'b1;
         bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;

   // ==========================================================
   // Registers
   // Only assigned bits are stored, so unassigned positions can never read back non-zero.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_periph_clock_gate_1_ff <= RUN_GATE_RESET; // [R03]
      end else if (wr_run) begin
         run_periph_clock_gate_1_ff <= ((run_periph_clock_gate_1_ff & ~wr_bits) |
                                        (wr_data_ff & wr_bits)) & RUN_GATE_RW_MASK; // [R11]
      end
   end

   // Interrupt mask.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_mask_ff <= STAT_RESET;
      end else if (do_write && (wr_addr_ff == IRQ_MASK_ADDR) && wr_strb_ff[0]) begin
         irq_mask_ff <= wr_data_ff[STAT_W-1:0];
      end
   end

   // Sticky events; a new event in the same cycle as its clearing write still sticks.
   always_comb begin
      stat_set = STAT_RESET;
      stat_set[STAT_FAULT_BIT] = |fault_vec;
      stat_set[STAT_CHANGE_BIT] = (nxt_enable != enable_ff);
      stat_clr = STAT_RESET;
      if (do_write && (wr_addr_ff == IRQ_STATUS_ADDR) && wr_strb_ff[0]) begin
         stat_clr = wr_data_ff[STAT_W-1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status_ff <= STAT_RESET;
      end else begin
         irq_status_ff <= (irq_status_ff & ~stat_clr) | stat_set;
      end
   end

   assign irq = |(irq_status_ff & irq_mask_ff);

   // ==========================================================
   // Read channel
   assign arready = !rvalid_ff;

   // Read decode; unmapped addresses return zero with a slave error.
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit = 1'b1;
      unique case (araddr)
         RUN_GATE_ADDR: rd_word = run_periph_clock_gate_1_ff; // [R12]
         IRQ_STATUS_ADDR: rd_word = {30'h0000_0000, irq_status_ff};
         IRQ_MASK_ADDR: rd_word = {30'h0000_0000, irq_mask_ff};
         FAULT_UNIT_ADDR: rd_word = {19'h0_0000, fault_unit_ff};
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid_ff <= 1'b1;
         rdata_ff <= rd_word;
         rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   assign rvalid = rvalid_ff;
   assign rdata = rdata_ff;
   assign rresp = rresp_ff;

   // ==========================================================
   // Enable selection
   // Deep sleep outranks sleep when the power controller raises both.
   always_comb begin
      if (deep_sleep_active) begin
         mode = MODE_DEEP;
      end else if (sleep_active) begin
         mode = MODE_SLEEP;
      end else begin
         mode = MODE_RUN;
      end
   end

   // Without automatic gating the run enables stay in force through sleep.
   always_comb begin
      sel_gate = run_periph_clock_gate_1_ff; // [R04]
      unique case (mode)
         MODE_RUN: sel_gate = run_periph_clock_gate_1_ff; // [R04]
         MODE_SLEEP: begin
            if (auto_sleep_gating_enable) begin
               sel_gate = sleep_periph_clock_gate_1; // [R05]
            end
         end
         MODE_DEEP: begin
            if (auto_sleep_gating_enable) begin
               sel_gate = deep_sleep_periph_clock_gate_1; // [R05]
            end
         end
         default: sel_gate = run_periph_clock_gate_1_ff;
      endcase
      nxt_enable = pick_enables(sel_gate & RUN_GATE_RW_MASK); // [R06] [R07] [R08] [R09] [R10]
   end

   // Registered so the gate cells see one clean change per cycle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable_ff <= '0; // [R03]
      end else begin
         enable_ff <= nxt_enable; // [R01]
      end
   end

   assign periph_clk_enable = enable_ff;

   // One gate cell per unit; a stopped clock also holds the unit disabled.
   genvar gi;
   generate
      for (gi = 0; gi < PERIPH_COUNT; gi++) begin : g_gate
         glitch_free_gate u_gate (
            .clk_in(aclk),
            .enable(enable_ff[gi]), // [R01]
            .clk_out(periph_gclk[gi]) // [R13]
         );
      end
   endgenerate

   // ==========================================================
   // Bus fault on access to unclocked units
   assign fault_vec = periph_access & ~enable_ff; // [R02]

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bus_fault_ff <= 1'b0;
      end else begin
         bus_fault_ff <= |fault_vec; // [R02]
      end
   end

   // Keeps the last offending unit set for software to inspect.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fault_unit_ff <= '0;
      end else if (|fault_vec) begin
         fault_unit_ff <= fault_vec;
      end
   end

   assign periph_bus_fault = bus_fault_ff;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_run_reset;
      $past(!aresetn) |-> (run_periph_clock_gate_1_ff == RUN_GATE_RESET) && (enable_ff == '0);
   endproperty
   a_run_reset: assert property (p_run_reset) else $error("gating not zero after reset"); // [R03]
   property p_write_reaches_clock;
      (wr_run && (wr_strb_ff == 4'hf) && (mode == MODE_RUN)) ##1 (mode == MODE_RUN)
         |=> enable_ff == pick_enables($past(wr_data_ff, 2) & RUN_GATE_RW_MASK);
   endproperty
   a_write_reaches_clock: assert property (p_write_reaches_clock) // [R01]
      else $error("written enable did not reach clock enables");
   property p_fault;
      (|fault_vec) |=> periph_bus_fault && (fault_unit_ff == $past(fault_vec));
   endproperty
   a_fault: assert property (p_fault) else $error("no bus fault on unclocked access"); // [R02]
   property p_no_fault;
      !(|fault_vec) |=> !periph_bus_fault;
   endproperty
   a_no_fault: assert property (p_no_fault) else $error("spurious bus fault"); // [R02]
   property p_run_mode_enables;
      (mode == MODE_RUN) |=> enable_ff == pick_enables($past(run_periph_clock_gate_1_ff));
   endproperty
   a_run_mode_enables: assert property (p_run_mode_enables) // [R04]
      else $error("run enables not applied while running");
   property p_sleep_ignored;
      (mode != MODE_RUN && !auto_sleep_gating_enable)
         |=> enable_ff == pick_enables($past(run_periph_clock_gate_1_ff));
   endproperty
   a_sleep_ignored: assert property (p_sleep_ignored) // [R05]
      else $error("sleep gating applied without auto gating");
   property p_deep_applied;
      (deep_sleep_active && auto_sleep_gating_enable) |=>
         enable_ff == pick_enables($past(deep_sleep_periph_clock_gate_1) & RUN_GATE_RW_MASK);
   endproperty
   a_deep_applied: assert property (p_deep_applied) // [R05]
      else $error("deep sleep gating not applied");
   property p_comp_bits;
      (mode == MODE_RUN) |-> {nxt_enable.comparator_b_clock_enable,
         nxt_enable.comparator_a_clock_enable} == run_periph_clock_gate_1_ff[25:24];
   endproperty
   a_comp_bits: assert property (p_comp_bits) else $error("comparator bit mapping"); // [R06]
   property p_counter_bits;
      (mode == MODE_RUN) |-> {nxt_enable.gp_counter_d_clock_enable,
         nxt_enable.gp_counter_c_clock_enable, nxt_enable.gp_counter_b_clock_enable,
         nxt_enable.gp_counter_a_clock_enable} == run_periph_clock_gate_1_ff[19:16];
   endproperty
   a_counter_bits: assert property (p_counter_bits) else $error("counter bit mapping"); // [R07]
   property p_two_wire_bits;
      (mode == MODE_RUN) |-> (nxt_enable.two_wire_b_clock_enable ==
         run_periph_clock_gate_1_ff[14]) && (nxt_enable.two_wire_a_clock_enable ==
         run_periph_clock_gate_1_ff[12]);
   endproperty
   a_two_wire_bits: assert property (p_two_wire_bits) else $error("two-wire mapping"); // [R08]
   property p_serial_bits;
      (mode == MODE_RUN) |-> {nxt_enable.sync_serial_b_clock_enable,
         nxt_enable.sync_serial_a_clock_enable} == run_periph_clock_gate_1_ff[5:4];
   endproperty
   a_serial_bits: assert property (p_serial_bits) else $error("sync serial mapping"); // [R09]
   property p_async_bits;
      (mode == MODE_RUN) |-> {nxt_enable.async_serial_c_clock_enable,
         nxt_enable.async_serial_b_clock_enable, nxt_enable.async_serial_a_clock_enable}
         == run_periph_clock_gate_1_ff[2:0];
   endproperty
   a_async_bits: assert property (p_async_bits) else $error("async serial mapping"); // [R10]
   property p_reserved_zero;
      rvalid_ff && $past(arvalid && arready && (araddr == RUN_GATE_ADDR)) |->
         (rdata_ff & ~RUN_GATE_RW_MASK) == 32'h0000_0000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read set"); // [R11]
   property p_other_addr_keeps;
      (do_write && (wr_addr_ff != RUN_GATE_ADDR)) |=> $stable(run_periph_clock_gate_1_ff);
   endproperty
   a_other_addr_keeps: assert property (p_other_addr_keeps) // [R12]
      else $error("gating changed by other address");

   property p_cover_fault;
      periph_bus_fault ##1 irq;
   endproperty
   c_cover_fault: cover property (p_cover_fault);
   property p_cover_sleep;
      (mode == MODE_RUN) ##1 (sleep_active && auto_sleep_gating_enable);
   endproperty
   c_cover_sleep: cover property (p_cover_sleep);
   property p_cover_enable;
      wr_run ##2 (enable_ff != '0);
   endproperty
   c_cover_enable: cover property (p_cover_enable);

endmodule
